// ===== design/mac_config.sv
// Measurement configuration registers and conversion sequencing
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R01 - Remote-two reading gets offset register added, 0.25 degree steps, reset zero.
// R02 - Offset is twos complement, may raise or lower the reading.
// R03 - With lock bit set, offset register ignores writes.
// R04 - Configuration register two resets to all zeros.
// R05 - Sense bit zero: fan speed measured from 3-wire tach.
// R06 - Sense bit one: input switched to 2-wire pulse sensing.
// R07 - Bit 4 disables averaging, conversions finish much faster.
// R08 - Bit 5 bypasses attenuators on the four voltage inputs.
// R09 - Bit 6 converts one selected channel repeatedly.
// R10 - Test bit 2 starts conversions on external clock edges, supplied outside.
// R11 - Single channel chosen by bits 7:5 of fan1 minimum high byte.
// R12 - Bit 7 shuts fans off, duty values kept.
module mac_config (
	input  wire logic              clk_sys_in,
	input  wire logic              nrst_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	input  wire logic [7:0]        reg_addr_in,
	input  wire logic [7:0]        reg_wdata_in,
	input  wire logic              fan1_tach_pin_in,
	input  wire logic signed [9:0] rem2_raw_in,
	input  wire logic              rem2_raw_valid_in,
	output logic [7:0]             reg_rdata_out,
	output logic                   reg_rvalid_out,
	output logic [3:0]             fan_two_wire_sel_out,
	output logic                   averaging_disable_out,
	output logic                   attenuator_bypass_out,
	output logic                   single_channel_convert_out,
	output logic                   fan_shutdown_out,
	output logic [2:0]             adc_channel_out,
	output logic                   single_channel_convert_start_out,
	output logic signed [9:0]      rem2_temp_out,
	output logic                   rem2_temp_valid_out
);
	typedef struct packed {
		logic [7:0] offset;
		logic [7:0] cfg2;
		logic [7:0] cfg1;
		logic [7:0] fan1_min_hi;
		logic [7:0] test2;
		logic [7:0] rdata;
		logic       rvalid;
		logic [2:0] chan;
		logic [9:0] cnt;
		logic       start;
		logic [2:0] tach_sync;
	} mac_st_type;

	mac_st_type s_q;
	mac_st_type s_d;
	logic       locked;
	logic       ext_edge;
	logic [9:0] scan_len;

	////////////////////////////////////////////////////////////////////////////
	// Write qualification and conversion pacing
	assign locked   = s_q.cfg1[mac_pkg::LOCK_BIT];
	// Rising edge taken from two synchronised stages only, never the first
	assign ext_edge = s_q.tach_sync[1] & ~s_q.tach_sync[2];
	// Averaging off shortens each conversion slot
	assign scan_len = s_q.cfg2[mac_pkg::AVG_DIS_BIT] ? mac_pkg::SCAN_FAST_CYCLES
		: mac_pkg::SCAN_AVG_CYCLES; // [R07]

	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.rvalid = reg_rd_in;
		s_d.tach_sync = {s_q.tach_sync[1:0], fan1_tach_pin_in};
		// Register writes; lock bit is sticky until reset
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				mac_pkg::REM2_OFFSET_ADDR: begin
					if (!locked)
						s_d.offset = reg_wdata_in; // [R03]
				end
				mac_pkg::MEAS_CFG2_ADDR: begin
					if (!locked)
						s_d.cfg2 = reg_wdata_in;
				end
				mac_pkg::LOCK_CFG1_ADDR: begin
					if (!locked)
						s_d.cfg1 = reg_wdata_in;
				end
				mac_pkg::FAN1_MIN_HI_ADDR: s_d.fan1_min_hi = reg_wdata_in;
				mac_pkg::TEST2_ADDR:       s_d.test2 = reg_wdata_in;
				default: ;
			endcase
		end
		// Read mux; unmapped addresses read zero
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				mac_pkg::REM2_OFFSET_ADDR: s_d.rdata = s_q.offset;
				mac_pkg::MEAS_CFG2_ADDR:   s_d.rdata = s_q.cfg2;
				mac_pkg::LOCK_CFG1_ADDR:   s_d.rdata = s_q.cfg1;
				mac_pkg::FAN1_MIN_HI_ADDR: s_d.rdata = s_q.fan1_min_hi;
				mac_pkg::TEST2_ADDR:       s_d.rdata = s_q.test2;
				default:                   s_d.rdata = 8'h00;
			endcase
		end
		// Conversion pacing: external clock edge or internal slot timer
		if (s_q.test2[mac_pkg::EXT_CLK_BIT]) begin
			s_d.cnt = 10'h000;
			s_d.start = ext_edge; // [R10]
		end else if (s_q.cnt >= scan_len - 10'h001) begin
			s_d.cnt = 10'h000;
			s_d.start = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 10'h001;
		end
		// Channel choice on each start
		if (s_q.start) begin
			if (s_q.cfg2[mac_pkg::SINGLE_SINGLE_CHANNEL_CONVERT_BIT])
				s_d.chan = s_q.fan1_min_hi[mac_pkg::CHSEL_LSB +: 3]; // [R09] [R11]
			else if (s_q.chan >= mac_pkg::NUM_CHANNELS - 3'h1)
				s_d.chan = mac_pkg::CHSEL_2V5;
			else
				s_d.chan = s_q.chan + 3'h1;
		end
	end

	// Single register stage holds every piece of state except the registered result inside the offset adder
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			s_q <= '0;
			s_q.offset <= mac_pkg::REM2_OFFSET_RESET; // [R01]
			s_q.cfg2 <= mac_pkg::MEAS_CFG2_RESET; // [R04]
			s_q.fan1_min_hi <= mac_pkg::FAN1_MIN_HI_RESET;
			s_q.test2 <= mac_pkg::TEST2_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata_out              = s_q.rdata;
	assign reg_rvalid_out             = s_q.rvalid;
	assign fan_two_wire_sel_out       = s_q.cfg2[3:0]; // [R05] [R06]
	assign averaging_disable_out      = s_q.cfg2[mac_pkg::AVG_DIS_BIT]; // [R07]
	assign attenuator_bypass_out      = s_q.cfg2[mac_pkg::ATTENUATOR_BYPASS_BYP_BIT]; // [R08]
	assign single_channel_convert_out = s_q.cfg2[mac_pkg::SINGLE_SINGLE_CHANNEL_CONVERT_BIT]; // [R09]
	// Duty registers live elsewhere and are untouched by shutdown
	assign fan_shutdown_out           = s_q.cfg2[mac_pkg::SHUTDOWN_BIT]; // [R12]
	assign adc_channel_out            = s_q.chan;
	assign single_channel_convert_start_out             = s_q.start;

	// Offset arithmetic kept apart so the adder can be reused per channel
	mac_offset_add u_add (
		.clk_sys_in     (clk_sys_in),
		.nrst_in        (nrst_in),
		.raw_temp_in    (rem2_raw_in),
		.raw_valid_in   (rem2_raw_valid_in),
		.offset_in      (s_q.offset),
		.temp_out       (rem2_temp_out),
		.temp_valid_out (rem2_temp_valid_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_lock_holds;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(locked && reg_wr_in && reg_addr_in == mac_pkg::REM2_OFFSET_ADDR) |=> $stable(s_q.offset);
	endproperty
	a_lock_holds: assert property (p_lock_holds) // [R03]
		else $error("offset changed while locked");

	property p_unlocked_write;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(!locked && reg_wr_in && reg_addr_in == mac_pkg::REM2_OFFSET_ADDR)
			|=> (s_q.offset == $past(reg_wdata_in));
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) // [R01]
		else $error("offset write not visible");

	property p_reset_zero;
		@(posedge clk_sys_in) $rose(nrst_in) |-> (s_q.cfg2 == 8'h00);
	endproperty
	a_reset_zero: assert property (p_reset_zero) // [R04]
		else $error("config two not zero after reset");

	property p_sense_sel;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(reg_wr_in && !locked && reg_addr_in == mac_pkg::MEAS_CFG2_ADDR)
			|=> (fan_two_wire_sel_out == $past(reg_wdata_in[3:0])); // [R05]
	endproperty
	a_sense_sel: assert property (p_sense_sel) // [R06]
		else $error("sense select not applied");

	property p_fast_slot;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(averaging_disable_out && !s_q.test2[mac_pkg::EXT_CLK_BIT])
			|=> (s_q.cnt < mac_pkg::SCAN_FAST_CYCLES);
	endproperty
	a_fast_slot: assert property (p_fast_slot) // [R07]
		else $error("fast slot count out of range");

	property p_single_chan;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(s_q.start && single_channel_convert_out)
			|=> (adc_channel_out == $past(s_q.fan1_min_hi[7:5]));
	endproperty
	a_single_chan: assert property (p_single_chan) // [R11]
		else $error("single channel not taken from selector");

	property p_ext_start;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(s_q.test2[mac_pkg::EXT_CLK_BIT] && $past(s_q.test2[mac_pkg::EXT_CLK_BIT]) && ext_edge)
			|=> single_channel_convert_start_out;
	endproperty
	a_ext_start: assert property (p_ext_start) // [R10]
		else $error("external edge did not start conversion");

	property p_shutdown;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(reg_wr_in && !locked && reg_addr_in == mac_pkg::MEAS_CFG2_ADDR)
			|=> (fan_shutdown_out == $past(reg_wdata_in[7]))
				&& (attenuator_bypass_out == $past(reg_wdata_in[5]))
				&& (single_channel_convert_out == $past(reg_wdata_in[6]));
	endproperty
	a_shutdown: assert property (p_shutdown) // [R12]
		else $error("config bits not applied");
endmodule

// ===== design/mac_pkg.sv
// Constants for the monitor measurement-configuration block
package mac_pkg;
	localparam logic [7:0] REM2_OFFSET_ADDR  = 8'h72;
	localparam logic [7:0] MEAS_CFG2_ADDR    = 8'h73;
	localparam logic [7:0] LOCK_CFG1_ADDR    = 8'h40;
	localparam logic [7:0] FAN1_MIN_HI_ADDR  = 8'h55;
	localparam logic [7:0] TEST2_ADDR        = 8'h7F;
	localparam logic [7:0] REM2_OFFSET_RESET = 8'h00;
	localparam logic [7:0] MEAS_CFG2_RESET   = 8'h00;
	localparam logic [7:0] FAN1_MIN_HI_RESET = 8'h00;
	localparam logic [7:0] TEST2_RESET       = 8'h00;
	localparam int         LOCK_BIT          = 1;
	localparam int         AVG_DIS_BIT       = 4;
	localparam int         ATTENUATOR_BYPASS_BYP_BIT      = 5;
	localparam int         SINGLE_SINGLE_CHANNEL_CONVERT_BIT   = 6;
	localparam int         SHUTDOWN_BIT      = 7;
	localparam int         EXT_CLK_BIT       = 2;
	localparam int         CHSEL_LSB         = 5;
	localparam logic [2:0] CHSEL_2V5         = 3'h0;
	localparam logic [2:0] NUM_CHANNELS      = 3'h7;
	localparam logic [9:0] SCAN_AVG_CYCLES   = 10'h100;
	localparam logic [9:0] SCAN_FAST_CYCLES  = 10'h010;
endpackage

// ===== design/mac_offset_add.sv
// Signed offset adder for the remote-two temperature reading
`timescale 1ns/100ps
module mac_offset_add (
	input  wire logic              clk_sys_in,
	input  wire logic              nrst_in,
	input  wire logic signed [9:0] raw_temp_in,
	input  wire logic              raw_valid_in,
	input  wire logic signed [7:0] offset_in,
	output logic signed [9:0]      temp_out,
	output logic                   temp_valid_out
);
	typedef struct packed {
		logic signed [9:0] temp;
		logic              vld;
	} mac_add_st_type;

	mac_add_st_type s_q;
	mac_add_st_type s_d;

	// Sum in quarter degrees, saturated so a big offset cannot wrap
	always_comb begin
		logic signed [10:0] sum;
		sum = 11'sh000;
		s_d = s_q;
		s_d.vld = raw_valid_in;
		if (raw_valid_in) begin
			sum = 11'(raw_temp_in) + 11'(offset_in); // [R01] [R02]
			if (sum > 11'sh1FF)
				s_d.temp = 10'sh1FF;
			else if (sum < -11'sh200)
				s_d.temp = -10'sh200;
			else
				s_d.temp = sum[9:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign temp_out       = s_q.temp;
	assign temp_valid_out = s_q.vld;

	property p_add_follows;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(raw_valid_in && raw_temp_in == 10'sh000) |=> (temp_out == 10'($past(offset_in)));
	endproperty
	a_add_follows: assert property (p_add_follows) // [R02]
		else $error("offset not added to zero reading");
endmodule

// ===== test/mac_host_model.sv
// Host management bus controller model for the register strobes
`timescale 1ns/100ps
module mac_host_model (
	input  wire logic       clk_sys_in,
	input  wire logic [7:0] reg_rdata_in,
	input  wire logic       reg_rvalid_in,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      reg_wdata_out
);
	// Idle bus
	initial begin
		{reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = 18'h00000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle write; idle lines show the inverse so stale data is never live
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		{reg_addr_out, reg_wdata_out, reg_wr_out} = {a, d, 1'b1};
		@(negedge clk_sys_in);
		{reg_addr_out, reg_wdata_out, reg_wr_out} = {~a, ~d, 1'b0};
	endtask

	// One-cycle read; data left unknown if no answer within four cycles
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		d = 8'hXX;
		@(negedge clk_sys_in);
		{reg_addr_out, reg_rd_out} = {a, 1'b1};
		@(negedge clk_sys_in);
		{reg_addr_out, reg_rd_out} = {~a, 1'b0};
		for (int i = 0; i < 4; i++) begin
			if (reg_rvalid_in === 1'b1) begin
				d = reg_rdata_in;
				break;
			end
			@(negedge clk_sys_in);
		end
	endtask
endmodule

// ===== test/test_monitor_adc_config.sv
// Self-checking bench for the measurement-configuration block
`timescale 1ns/100ps
module test_monitor_adc_config;
	typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} mac_row_type;
	logic              clk_sys_in = 1'b0, nrst_in = 1'b0, tach = 1'b0, raw_vld = 1'b0;
	logic signed [9:0] raw = 10'h000, temp;
	logic [7:0]        addr, wdata, rdata, rd_val, cfg_exp, off_exp;
	logic [3:0]        two_wire;
	logic [9:0]        cfg_now;
	logic [2:0]        ch, prev;
	logic              wr, rd, rvalid, averaging_disable, attenuator_bypass, single, fan_shutdown, start, temp_vld;
	int                n_errors = 0, n_tests = 0, gap;
	mac_row_type       rows [14] = '{'{8'h72, 8'h04, 8'h04}, '{8'h72, 8'hFC, 8'hFC},
		'{8'h73, 8'h01, 8'h01}, '{8'h73, 8'h02, 8'h02}, '{8'h73, 8'h04, 8'h04},
		'{8'h73, 8'h08, 8'h08}, '{8'h73, 8'h10, 8'h10}, '{8'h73, 8'h20, 8'h20},
		'{8'h73, 8'h40, 8'h40}, '{8'h73, 8'h80, 8'h80}, '{8'h55, 8'hA0, 8'hA0},
		'{8'h11, 8'h33, 8'h00}, '{8'h73, 8'h00, 8'h00}, '{8'h72, 8'h00, 8'h00}};

	// 50 MHz system clock
	always #10 clk_sys_in = ~clk_sys_in;

	mac_config i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .fan1_tach_pin_in(tach),
		.rem2_raw_in(raw), .rem2_raw_valid_in(raw_vld), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .fan_two_wire_sel_out(two_wire),
		.averaging_disable_out(averaging_disable), .attenuator_bypass_out(attenuator_bypass),
		.single_channel_convert_out(single), .fan_shutdown_out(fan_shutdown),
		.adc_channel_out(ch), .single_channel_convert_start_out(start), .rem2_temp_out(temp),
		.rem2_temp_valid_out(temp_vld));
	mac_host_model i_host (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata),
		.reg_rvalid_in(rvalid), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
		.reg_wdata_out(wdata));

	// Configuration outputs gathered in register bit order
	assign cfg_now = {2'h0, fan_shutdown, single, attenuator_bypass, averaging_disable, two_wire};

	////////////////////////////////////////////////////////////////////////////////
	// Single compare, counted
	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Saturating add, kept separate from the design's arithmetic
	function automatic logic [9:0] sat(input int r, input logic signed [7:0] o);
		int s;
		s = r + int'(o);
		return (s > 511) ? 10'h1FF : (s < -512) ? 10'h200 : 10'(s);
	endfunction

	task automatic temp_chk(input logic signed [9:0] r, input logic [9:0] e);
		@(negedge clk_sys_in);
		{raw, raw_vld} = {r, 1'b1};
		@(negedge clk_sys_in);
		{raw, raw_vld} = {~r, 1'b0};
		check({temp_vld, 9'h000}, 10'h200, "temp valid");
		check(temp, e, "temp");
	endtask

	// Cycles until the next start pulse, bounded; channel settled on return
	task automatic wait_start(output int n);
		n = 0;
		while (start !== 1'b1 && n < 600) begin
			@(negedge clk_sys_in);
			n++;
		end
		@(negedge clk_sys_in);
		n++;
	endtask

	// Watchdog well past the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_errors++;
		conclude();
	end

	initial begin
		repeat (12) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		nrst_in = 1'b1;
		{cfg_exp, off_exp} = 16'h0000;
		foreach (rows[i]) begin
			i_host.wr(rows[i].addr, rows[i].data);
			if (rows[i].addr == 8'h73) cfg_exp = rows[i].data;
			if (rows[i].addr == 8'h72) off_exp = rows[i].data;
			i_host.rd(rows[i].addr, rd_val);
			check({2'h0, rd_val}, {2'h0, rows[i].exp}, "read");
			check(cfg_now, {2'h0, cfg_exp}, "cfg");
			temp_chk(10'sh064, sat(100, off_exp));
			$display("Row %0d done", i);
		end
		// Saturation at both ends of the reading range
		i_host.wr(8'h72, 8'h7F);
		temp_chk(10'sh1F4, sat(500, 8'h7F));
		i_host.wr(8'h72, 8'h80);
		temp_chk(-10'sh1FE, sat(-510, 8'h80));
		temp_chk(10'sh000, sat(0, 8'h80));
		$display("Saturation tests done");
		// Start spacing with and without averaging, and scan order
		wait_start(gap);
		wait_start(gap);
		check(10'(gap), mac_pkg::SCAN_AVG_CYCLES, "slow gap");
		i_host.wr(8'h73, 8'h10);
		wait_start(gap);
		prev = ch;
		wait_start(gap);
		check(10'(gap), mac_pkg::SCAN_FAST_CYCLES, "fast gap");
		check({7'h00, ch}, {7'h00, (prev == 3'h6) ? 3'h0 : prev + 3'h1}, "scan");
		// Single channel taken from the fan1 minimum high byte
		i_host.wr(8'h73, 8'h50);
		wait_start(gap);
		wait_start(gap);
		check({7'h00, ch}, 10'h005, "single ch");
		$display("Timing tests done");
		// External clock on the tach pin right after a timer start
		i_host.wr(8'h73, 8'h40);
		wait_start(gap);
		i_host.wr(8'h7F, 8'h04);
		tach = 1'b1;
		gap = 0;
		while (start !== 1'b1 && gap < 8) begin
			@(negedge clk_sys_in);
			gap++;
		end
		check({9'h000, start}, 10'h001, "ext start");
		check(10'(gap), 10'h003, "ext delay");
		tach = 1'b0;
		i_host.wr(8'h7F, 8'h00);
		$display("External start test done");
		// Lock freezes offset and configuration writes
		i_host.wr(8'h72, 8'h11);
		i_host.wr(8'h40, 8'h02);
		i_host.wr(8'h72, 8'h22);
		i_host.wr(8'h73, 8'h01);
		i_host.rd(8'h72, rd_val);
		check({2'h0, rd_val}, 10'h011, "locked offset");
		check(cfg_now, 10'h040, "locked cfg");
		temp_chk(10'sh064, sat(100, 8'h11));
		temp_chk(10'sh000, sat(0, 8'h11));
		// Mid-run reset clears registers and the lock
		@(negedge clk_sys_in);
		nrst_in = 1'b0;
		repeat (12) @(negedge clk_sys_in);
		nrst_in = 1'b1;
		i_host.rd(8'h72, rd_val);
		check({2'h0, rd_val}, 10'h000, "reset offset");
		check(cfg_now, 10'h000, "reset cfg");
		// Lock must be gone after reset, so the offset accepts writes again
		i_host.wr(8'h72, 8'h33);
		i_host.rd(8'h72, rd_val);
		check({2'h0, rd_val}, 10'h033, "unlock after reset");
		$display("Lock and reset tests done");
		conclude();
	end
endmodule
